/* shared/pic_pkg.sv */
// Constants, register map and types of the priority interrupt controller
package pic_pkg;
    // Sizes
    localparam int NUM_SRC = 86;
    localparam int NUM_LEVELS = 4;
    localparam int SRC_W = 7;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int REG_AW = 6;
    localparam int VB_W = ADDR_W - SRC_W;
    localparam int FVH_W = ADDR_W - DATA_W;
    localparam int FIELDS_PER_WORD = 8;
    localparam int MAX_SRC = 128;

    // Register offsets, word addressed
    localparam logic [5:0] OFF_PRIO = 6'h00;
    localparam logic [5:0] OFF_VBASE = 6'h10;
    localparam logic [5:0] OFF_FM0 = 6'h11;
    localparam logic [5:0] OFF_FVL0 = 6'h12;
    localparam logic [5:0] OFF_FVH0 = 6'h13;
    localparam logic [5:0] OFF_FM1 = 6'h14;
    localparam logic [5:0] OFF_FVL1 = 6'h15;
    localparam logic [5:0] OFF_FVH1 = 6'h16;
    localparam logic [5:0] OFF_CTRL = 6'h17;
    localparam logic [5:0] OFF_STAT = 6'h18;
    localparam logic [5:0] OFF_MASK = 6'h19;
    localparam logic [5:0] OFF_PEND = 6'h20;

    // Field positions
    localparam int CTRL_EDGE_A_BIT = 0;
    localparam int CTRL_EDGE_B_BIT = 1;
    localparam int STAT_ACK_BIT = 0;
    localparam int STAT_WAKE_BIT = 1;

    // Reset values
    localparam logic [1:0] FIELD_OFF = 2'h0;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] STAT_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [VB_W-1:0] VBASE_RST = 14'h0000;
    localparam logic [SRC_W-1:0] FM_RST = 7'h00;
    localparam logic [ADDR_W-1:0] RESET_FETCH_ADDR = 21'h000000;

    // Level indication sent to the core
    typedef enum logic [1:0] {
        CODE_NONE = 2'h0,
        CODE_L0 = 2'h1,
        CODE_L1 = 2'h2,
        CODE_L23 = 2'h3
    } pic_level_code_t;

    // Operating mode, Gray along functional, wait, stop
    typedef enum logic [1:0] {
        MODE_FUNC = 2'h0,
        MODE_WAIT = 2'h1,
        MODE_STOP = 2'h3
    } pic_mode_t;
endpackage

/* design/pic_lowest_enc.sv */
// Priority encoder returning the lowest numbered active request
`timescale 1ns/1ps
`default_nettype none
module pic_lowest_enc #(
    parameter int N = 86,
    parameter int IW = 7
) (
    // Requests of one level
    input wire logic [N-1:0] req,
    // Result
    output logic any,
    output logic [IW-1:0] idx
);
    // Scan downward so the lowest set bit is taken last
    always_comb begin
        any = |req;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = IW'(i);
            end
        end
    end
endmodule // pic_lowest_enc
`default_nettype wire

/* design/pic_interrupt_arbiter.sv */
// Prioritised interrupt arbiter with fast vectors and low-power wakeup
//
// How it works
// - 86 sources, each except fixed sources 0-2 with programmable level
// - Lowest source number wins within level
// - Vector address is base concatenated with number
// - Core mask admits only sufficiently high levels
// - Two-bit level code reported to core
// - Matching level-two request uses fast address
// - Fast decision made here, before core
// - Functional mode after reset
// - Pending request in low power requests wakeup
// - Only requests enabled before entry wake
// - External requests level sensitive in low power
// - Stop wakes only on CAN or external
// - Reset fetch address driven after reset
// - Tell core of request with address
// - Field 00 disables; others select 1-3
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pic_interrupt_arbiter #(
    parameter int NUM_SRC = pic_pkg::NUM_SRC,
    parameter logic [NUM_SRC-1:0] FIXED3_MASK = NUM_SRC'(8'h03),
    parameter logic [NUM_SRC-1:0] SW0_MASK = NUM_SRC'(8'h04),
    parameter int EXT_A_SRC = 5,
    parameter int EXT_B_SRC = 6,
    parameter int CAN_SRC = 7
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [pic_pkg::REG_AW-1:0] reg_addr,
    input wire logic [pic_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [pic_pkg::DATA_W-1:0] reg_rdata,
    // Interrupt sources
    input wire logic [NUM_SRC-1:0] irq_src,
    input wire logic external_request_a_n,
    input wire logic external_request_b_n,
    // System integration unit
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic wake_req,
    // Core side
    input wire logic [1:0] core_mask,
    input wire logic int_ack,
    output logic int_req,
    output logic [pic_pkg::SRC_W-1:0] int_vector,
    output logic [pic_pkg::ADDR_W-1:0] int_addr,
    output logic int_fast,
    output logic [1:0] current_level_code,
    output logic boot_fetch,
    // Interrupt to system
    output logic irq
);
    localparam int SW = pic_pkg::SRC_W;
    localparam int NL = pic_pkg::NUM_LEVELS;

    // Refuse configurations the map and encoders cannot hold
    if (NUM_SRC < 1 || NUM_SRC > pic_pkg::MAX_SRC || EXT_A_SRC >= NUM_SRC ||
        EXT_B_SRC >= NUM_SRC || CAN_SRC >= NUM_SRC) begin : g_bad_cfg
        $error("pic_interrupt_arbiter: unsupported source configuration");
    end

    // Software visible state
    logic [pic_pkg::VB_W-1:0] vector_base;
    logic [SW-1:0] fast_match_0, fast_match_1;
    logic [15:0] fast_vector_low_0, fast_vector_low_1;
    logic [pic_pkg::FVH_W-1:0] fast_vector_high_0, fast_vector_high_1;
    logic [1:0] ctrl; // External edge selects
    logic [1:0] stat; // Sticky events
    logic [1:0] stat_mask;
    // Per-source views
    logic [2*NUM_SRC-1:0] priority_fields;
    logic [NUM_SRC-1:0] src_en, active, en_snap, wake_hit;
    logic [NUM_SRC-1:0] lvl_req [NL];
    logic [NL-1:0] any_l;
    logic [SW-1:0] idx_l [NL];
    logic [1:0] ext_act;
    // Mode tracking
    pic_pkg::pic_mode_t mode, next_mode;
    // Arbitration results
    logic next_req, next_fast, next_wake;
    logic [1:0] win_lvl, lvl_q;
    logic [SW-1:0] win_idx;
    logic [pic_pkg::ADDR_W-1:0] next_addr;
    logic [NUM_SRC-1:0] low_mask;
    logic [1:0] stat_set, stat_clr;

    // Per-source priority field, level decode and request routing
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        localparam int W = i / pic_pkg::FIELDS_PER_WORD;
        localparam int B = (i % pic_pkg::FIELDS_PER_WORD) * 2;
        logic [1:0] field;
        logic [1:0] level;
        // Field write
        always_ff @(posedge mclk) begin
            if (rst) begin
                field <= pic_pkg::FIELD_OFF;
            end else if (reg_wr && reg_addr == pic_pkg::OFF_PRIO + 6'(W)) begin
                field <= reg_wdata[B +: 2];
            end
        end
        // Fixed sources ignore their field; 00 disables the rest
        assign level = FIXED3_MASK[i] ? 2'h3 : (SW0_MASK[i] ? 2'h0 : field);
        assign src_en[i] = FIXED3_MASK[i] | SW0_MASK[i] | (field != pic_pkg::FIELD_OFF);
        assign priority_fields[2*i +: 2] = field;
        // External pins merge into their source slots
        assign active[i] = irq_src[i] | ((i == EXT_A_SRC) && ext_act[0]) |
                           ((i == EXT_B_SRC) && ext_act[1]);
        // Stop mode: only clockless sources may wake
        assign wake_hit[i] = active[i] && en_snap[i] &&
            (mode != pic_pkg::MODE_STOP || i == CAN_SRC ||
             i == EXT_A_SRC || i == EXT_B_SRC);
        for (genvar k = 0; k < NL; k++) begin : g_lvl
            assign lvl_req[k][i] = active[i] && src_en[i] && (level == 2'(k));
        end
    end

    // One encoder per level
    for (genvar k = 0; k < NL; k++) begin : g_enc
        pic_lowest_enc #(.N(NUM_SRC), .IW(SW)) u_enc (
            .req(lvl_req[k]),
            .any(any_l[k]),
            .idx(idx_l[k])
        );
    end

    // External request pins, edge or level sensitive
    for (genvar e = 0; e < 2; e++) begin : g_ext
        localparam int ES = (e == 0) ? EXT_A_SRC : EXT_B_SRC;
        logic pin_low, prev_low, pend, edge_mode;
        assign pin_low = (e == 0) ? !external_request_a_n : !external_request_b_n;
        // No clock in low power, so edge mode falls back to level
        assign edge_mode = ctrl[e] && (mode == pic_pkg::MODE_FUNC);
        always_ff @(posedge mclk) begin
            if (rst) begin
                prev_low <= 1'b0;
                pend <= 1'b0;
            end else begin
                prev_low <= pin_low;
                // A falling edge beats a same-cycle acknowledge
                if (edge_mode && pin_low && !prev_low) begin
                    pend <= 1'b1;
                end else if (!edge_mode || (int_ack && int_vector == SW'(ES))) begin
                    pend <= 1'b0;
                end
            end
        end
        assign ext_act[e] = edge_mode ? pend : pin_low;
    end

    // Mode follows the system inputs, stop taking precedence
    always_comb begin
        if (stop_mode) begin
            next_mode = pic_pkg::MODE_STOP;
        end else if (wait_mode) begin
            next_mode = pic_pkg::MODE_WAIT;
        end else begin
            next_mode = pic_pkg::MODE_FUNC;
        end
    end

    // Mode register and enable snapshot on entry to low power
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode <= pic_pkg::MODE_FUNC;
            en_snap <= '0;
        end else begin
            mode <= next_mode;
            case (mode)
                pic_pkg::MODE_FUNC: begin
                    // Enables as they stood before entry
                    if (next_mode != pic_pkg::MODE_FUNC) begin
                        en_snap <= src_en;
                    end
                end
                pic_pkg::MODE_WAIT, pic_pkg::MODE_STOP: begin
                    en_snap <= en_snap;
                end
                default: begin
                    en_snap <= '0;
                end
            endcase
        end
    end

    // Highest admitted level wins; lower loop indices are overwritten
    always_comb begin
        next_req = 1'b0;
        win_lvl = 2'h0;
        win_idx = '0;
        for (int k = 0; k < NL; k++) begin
            if (any_l[k] && 2'(k) >= core_mask) begin
                next_req = 1'b1;
                win_lvl = 2'(k);
                win_idx = idx_l[k];
            end
        end
    end

    // Fast channel check, channel 0 preferred on a double match
    always_comb begin
        next_fast = next_req && win_lvl == 2'h2 &&
                    (win_idx == fast_match_0 || win_idx == fast_match_1);
        if (next_fast && win_idx == fast_match_0) begin
            next_addr = {fast_vector_high_0, fast_vector_low_0};
        end else if (next_fast) begin
            next_addr = {fast_vector_high_1, fast_vector_low_1};
        end else begin
            next_addr = {vector_base, win_idx};
        end
    end

    assign next_wake = (mode != pic_pkg::MODE_FUNC) && (|wake_hit);

    // Core request outputs; reset address held through first cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_fetch <= 1'b1;
            int_addr <= pic_pkg::RESET_FETCH_ADDR;
            int_req <= 1'b0;
            int_fast <= 1'b0;
            int_vector <= '0;
            lvl_q <= 2'h0;
            current_level_code <= pic_pkg::CODE_NONE;
        end else begin
            boot_fetch <= 1'b0;
            int_addr <= boot_fetch ? pic_pkg::RESET_FETCH_ADDR : next_addr;
            int_req <= next_req && !boot_fetch;
            int_fast <= next_fast && !boot_fetch;
            int_vector <= win_idx;
            lvl_q <= win_lvl;
            // Level 1 shares no code with level 0 here
            if (!next_req || boot_fetch) begin
                current_level_code <= pic_pkg::CODE_NONE;
            end else if (win_lvl == 2'h0) begin
                current_level_code <= pic_pkg::CODE_L0;
            end else if (win_lvl == 2'h1) begin
                current_level_code <= pic_pkg::CODE_L1;
            end else begin
                current_level_code <= pic_pkg::CODE_L23;
            end
        end
    end

    // Wakeup line to the system integration unit
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= next_wake;
        end
    end

    // Configuration writes
    always_ff @(posedge mclk) begin
        if (rst) begin
            vector_base <= pic_pkg::VBASE_RST;
            fast_match_0 <= pic_pkg::FM_RST;
            fast_match_1 <= pic_pkg::FM_RST;
            fast_vector_low_0 <= '0;
            fast_vector_low_1 <= '0;
            fast_vector_high_0 <= '0;
            fast_vector_high_1 <= '0;
            ctrl <= pic_pkg::CTRL_RST;
            stat_mask <= pic_pkg::MASK_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                pic_pkg::OFF_VBASE: vector_base <= reg_wdata[pic_pkg::VB_W-1:0];
                pic_pkg::OFF_FM0: fast_match_0 <= reg_wdata[SW-1:0];
                pic_pkg::OFF_FVL0: fast_vector_low_0 <= reg_wdata;
                pic_pkg::OFF_FVH0: fast_vector_high_0 <= reg_wdata[pic_pkg::FVH_W-1:0];
                pic_pkg::OFF_FM1: fast_match_1 <= reg_wdata[SW-1:0];
                pic_pkg::OFF_FVL1: fast_vector_low_1 <= reg_wdata;
                pic_pkg::OFF_FVH1: fast_vector_high_1 <= reg_wdata[pic_pkg::FVH_W-1:0];
                pic_pkg::OFF_CTRL: begin
                    ctrl <= reg_wdata[pic_pkg::CTRL_EDGE_B_BIT:pic_pkg::CTRL_EDGE_A_BIT];
                end
                pic_pkg::OFF_MASK: stat_mask <= reg_wdata[1:0];
                default: begin
                    // Unmapped or read-only: ignored
                end
            endcase
        end
    end

    // Sticky events, cleared by reading; a new event wins over the clear
    assign stat_set[pic_pkg::STAT_ACK_BIT] = int_ack;
    assign stat_set[pic_pkg::STAT_WAKE_BIT] = next_wake && !wake_req;
    assign stat_clr = (reg_rd && reg_addr == pic_pkg::OFF_STAT) ? 2'h3 : 2'h0;
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat <= pic_pkg::STAT_RST;
            irq <= 1'b0;
        end else begin
            stat <= (stat & ~stat_clr) | stat_set;
            irq <= |(stat & stat_mask);
        end
    end

    // Read data for exactly one cycle; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= '0;
            if (reg_rd) begin
                if (reg_addr[5:4] == 2'h0) begin
                    reg_rdata <= 16'(256'(priority_fields) >> {reg_addr[3:0], 4'h0});
                end else if (reg_addr[5:3] == 3'h4) begin
                    reg_rdata <= 16'(128'(active) >> {reg_addr[2:0], 4'h0});
                end else begin
                    case (reg_addr)
                        pic_pkg::OFF_VBASE: reg_rdata <= 16'(vector_base);
                        pic_pkg::OFF_FM0: reg_rdata <= 16'(fast_match_0);
                        pic_pkg::OFF_FVL0: reg_rdata <= fast_vector_low_0;
                        pic_pkg::OFF_FVH0: reg_rdata <= 16'(fast_vector_high_0);
                        pic_pkg::OFF_FM1: reg_rdata <= 16'(fast_match_1);
                        pic_pkg::OFF_FVL1: reg_rdata <= fast_vector_low_1;
                        pic_pkg::OFF_FVH1: reg_rdata <= 16'(fast_vector_high_1);
                        pic_pkg::OFF_CTRL: reg_rdata <= 16'(ctrl);
                        pic_pkg::OFF_STAT: reg_rdata <= 16'(stat);
                        pic_pkg::OFF_MASK: reg_rdata <= 16'(stat_mask);
                        default: reg_rdata <= '0;
                    endcase
                end
            end
        end
    end

    // Helper for the lowest-number check
    assign low_mask = (NUM_SRC'(1) << win_idx) - NUM_SRC'(1);

    AST_BOOT_ADDR: assert property (@(posedge mclk) disable iff (rst)
        $fell(rst) |-> boot_fetch && int_addr == pic_pkg::RESET_FETCH_ADDR && !int_req)
        else $error("reset fetch address not presented");
    AST_MASK_LEVEL: assert property (@(posedge mclk) disable iff (rst)
        int_req |-> lvl_q >= $past(core_mask))
        else $error("masked level presented to core");
    AST_LOWEST: assert property (@(posedge mclk) disable iff (rst)
        next_req |-> lvl_req[win_lvl][win_idx] && (lvl_req[win_lvl] & low_mask) == '0)
        else $error("lower numbered source skipped");
    AST_TOP_LEVEL: assert property (@(posedge mclk) disable iff (rst)
        any_l[3] && !boot_fetch |=> int_req && lvl_q == 2'h3)
        else $error("level three request not presented first");
    AST_VEC_ADDR: assert property (@(posedge mclk) disable iff (rst)
        int_req && !int_fast |-> int_addr == {$past(vector_base), int_vector})
        else $error("normal vector address wrong");
    AST_FAST_ADDR: assert property (@(posedge mclk) disable iff (rst)
        int_fast && int_vector == $past(fast_match_0) |->
        lvl_q == 2'h2 && int_addr == {$past(fast_vector_high_0), $past(fast_vector_low_0)})
        else $error("fast channel 0 address wrong");
    AST_FAST_DECIDE: assert property (@(posedge mclk) disable iff (rst)
        next_req && !boot_fetch && win_lvl == 2'h2 && win_idx == fast_match_1 |=> int_fast)
        else $error("fast match not flagged");
    AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
        mode != pic_pkg::MODE_FUNC && (|(active & en_snap)) &&
        mode != pic_pkg::MODE_STOP |=> wake_req)
        else $error("pending request did not wake");
    AST_FUNC_NO_WAKE: assert property (@(posedge mclk) disable iff (rst)
        mode == pic_pkg::MODE_FUNC |=> !wake_req)
        else $error("wakeup raised in functional mode");
    AST_STOP_SRC: assert property (@(posedge mclk) disable iff (rst)
        wake_req && $past(mode) == pic_pkg::MODE_STOP |-> $past(|wake_hit))
        else $error("stop wakeup from clocked source");
    AST_EXT_LEVEL: assert property (@(posedge mclk) disable iff (rst)
        mode != pic_pkg::MODE_FUNC && !external_request_a_n |-> ext_act[0])
        else $error("external request not level sensitive");
    AST_ACK_STICKY: assert property (@(posedge mclk) disable iff (rst)
        int_ack |=> stat[pic_pkg::STAT_ACK_BIT] ##1 (irq || !$past(stat_mask[0])))
        else $error("acknowledge event lost");
    AST_LEVEL_CODE: assert property (@(posedge mclk) disable iff (rst)
        int_req && lvl_q[1] |-> current_level_code == pic_pkg::CODE_L23)
        else $error("level code wrong for level two or three");
endmodule // pic_interrupt_arbiter
`default_nettype wire

/* test/pic_core_model.sv */
// Core-side model: acknowledges each presented interrupt once
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Controller side
    input wire logic int_req,
    input wire logic int_fast,
    input wire logic auto_ack,
    output logic int_ack,
    // Count of fast handler entries
    output logic [7:0] fast_cnt
);
    logic seen; // Ack already given for this request
    // One ack per request; a slow core is had by holding auto_ack low
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_ack <= 1'b0;
            seen <= 1'b0;
            fast_cnt <= 8'h00;
        end else begin
            int_ack <= auto_ack && int_req && !seen && !int_ack;
            seen <= int_req && (seen || int_ack);
            // Fetched word is never a subroutine jump, so fast entry follows
            if (int_ack && int_fast) fast_cnt <= fast_cnt + 8'h01;
        end
    end
endmodule // pic_core_model
`default_nettype wire

/* test/priority_interrupt_controller_tb.sv */
// Self-checking bench of the priority interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_tb;
    logic mclk, rst, reg_wr, reg_rd, ext_a_n, ext_b_n, wait_mode, stop_mode;
    logic int_ack, int_req, int_fast, wake_req, boot_fetch, irq, auto_ack;
    logic [5:0] reg_addr; // Register bus
    logic [15:0] reg_wdata, reg_rdata;
    logic [85:0] irq_src;
    logic [1:0] core_mask, level_code;
    logic [6:0] int_vector;
    logic [20:0] int_addr;
    logic [7:0] fast_cnt;
    logic [15:0] prio [16]; // Shadow of the priority words
    int n_errors = 0;
    int compares = 0;
    int srcs [4] = '{2, 12, 20, 30}; // One source per level
    logic [1:0] codes [4] = '{2'h1, 2'h2, 2'h3, 2'h3};

    pic_interrupt_arbiter u_dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_src(irq_src),
        .external_request_a_n(ext_a_n), .external_request_b_n(ext_b_n),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .wake_req(wake_req),
        .core_mask(core_mask), .int_ack(int_ack), .int_req(int_req),
        .int_vector(int_vector), .int_addr(int_addr), .int_fast(int_fast),
        .current_level_code(level_code), .boot_fetch(boot_fetch), .irq(irq));
    pic_core_model u_core (
        .mclk(mclk), .rst(rst), .int_req(int_req), .int_fast(int_fast),
        .auto_ack(auto_ack), .int_ack(int_ack), .fast_cnt(fast_cnt));

    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read strobe, data taken in the following cycle only
    task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Whole word rewritten, so the shadow keeps neighbours intact
    task automatic set_lvl(input int s, input logic [1:0] l);
        prio[s / 8][(s % 8) * 2 +: 2] = l;
        wr(6'(s / 8), prio[s / 8]);
    endtask
    task automatic only(input int s);
        @(posedge mclk) irq_src <= 86'h1 << s;
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic end_sim;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog, far beyond the expected run length
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end

    initial begin
        foreach (prio[i]) prio[i] = 16'h0000;
        {rst, reg_wr, reg_rd, wait_mode, stop_mode, auto_ack} = 6'b100001;
        {ext_a_n, ext_b_n, core_mask, reg_addr, reg_wdata} = '1;
        irq_src = '0;
        core_mask = 2'h0;
        repeat (5) @(posedge mclk);
        #1 chk({boot_fetch, int_req, int_addr}, 23'h400000);
        @(posedge mclk) rst <= 1'b0;
        // Boot flag drops at the first edge, reset address still shown
        @(posedge mclk);
        #1 chk({boot_fetch, int_addr}, 22'h000000);
        @(posedge mclk);
        #1 chk({boot_fetch, int_req}, 2'h0);
        rdc(pic_pkg::OFF_VBASE, 16'h0000);
        rdc(pic_pkg::OFF_MASK, 16'h0000);
        rdc(6'h3f, 16'h0000);
        $display("test reset done");
        // Arbitration inside and across levels
        wr(pic_pkg::OFF_VBASE, 16'h2a5c);
        set_lvl(9, 2'h2);
        set_lvl(12, 2'h1);
        set_lvl(20, 2'h2);
        set_lvl(30, 2'h3);
        set_lvl(85, 2'h1);
        @(posedge mclk) irq_src <= (86'h1 << 9) | (86'h1 << 20) | (86'h1 << 85);
        settle();
        chk({int_req, int_vector}, {1'b1, 7'd9});
        chk(int_addr, {14'h2a5c, 7'd9});
        only(85);
        settle();
        chk(int_vector, 7'd85);
        @(posedge mclk) irq_src <= irq_src | (86'h1 << 12) | (86'h1 << 30);
        settle();
        chk(int_vector, 7'd30);
        // Pending word 1 shows source 30 at bit 14
        rdc(pic_pkg::OFF_PEND + 6'h1, 16'h4000);
        $display("test priority done");
        // Core mask against each level
        for (int l = 0; l < 4; l++) begin
            for (int m = 0; m < 4; m++) begin
                only(srcs[l]);
                @(posedge mclk) core_mask <= 2'(m);
                settle();
                chk(int_req, l >= m);
                if (l >= m) chk(level_code, codes[l]);
            end
        end
        @(posedge mclk) core_mask <= 2'h0;
        set_lvl(20, 2'h0);
        only(20);
        settle();
        chk(int_req, 1'b0);
        $display("test mask done");
        // Fast channels
        set_lvl(20, 2'h2);
        wr(pic_pkg::OFF_FM0, 16'h0014);
        wr(pic_pkg::OFF_FVL0, 16'h1234);
        wr(pic_pkg::OFF_FVH0, 16'h0015);
        settle();
        chk({int_fast, int_addr}, {1'b1, 5'h15, 16'h1234});
        wr(pic_pkg::OFF_FM1, 16'h000c);
        wr(pic_pkg::OFF_FVL1, 16'hbeef);
        wr(pic_pkg::OFF_FVH1, 16'h000a);
        only(12);
        settle();
        chk({int_fast, int_addr}, {1'b0, 14'h2a5c, 7'd12});
        set_lvl(12, 2'h2);
        settle();
        chk({int_fast, int_addr}, {1'b1, 5'h0a, 16'hbeef});
        $display("test fast done");
        // Wakeup status, interrupt raise, mask and clear
        @(posedge mclk) irq_src <= '0;
        @(posedge mclk) auto_ack <= 1'b0;
        wr(pic_pkg::OFF_MASK, 16'h0003);
        rdc(pic_pkg::OFF_STAT, 16'h0001);
        @(posedge mclk) wait_mode <= 1'b1;
        only(20);
        settle();
        chk({wake_req, irq}, 2'h3);
        rdc(pic_pkg::OFF_STAT, 16'h0002);
        settle();
        chk(irq, 1'b0);
        @(posedge mclk) auto_ack <= 1'b1;
        settle();
        chk(irq, 1'b1);
        // First acknowledge taken while source 20 is a fast one
        chk(fast_cnt, 8'h01);
        wr(pic_pkg::OFF_MASK, 16'h0000);
        settle();
        chk(irq, 1'b0);
        rdc(pic_pkg::OFF_STAT, 16'h0001);
        // Enabled only after entry: no wake
        @(posedge mclk) wait_mode <= 1'b0;
        set_lvl(20, 2'h0);
        @(posedge mclk) wait_mode <= 1'b1;
        set_lvl(20, 2'h2);
        settle();
        chk(wake_req, 1'b0);
        @(posedge mclk) wait_mode <= 1'b0;
        $display("test wait done");
        // Stop mode wake sources
        set_lvl(5, 2'h2);
        set_lvl(7, 2'h2);
        wr(pic_pkg::OFF_CTRL, 16'h0001);
        @(posedge mclk) stop_mode <= 1'b1;
        settle();
        chk(wake_req, 1'b0);
        only(0);
        @(posedge mclk) ext_a_n <= 1'b0;
        settle();
        chk(wake_req, 1'b1);
        @(posedge mclk) ext_a_n <= 1'b1;
        only(7);
        settle();
        chk(wake_req, 1'b1);
        $display("test stop done");
        end_sim();
    end
endmodule // priority_interrupt_controller_tb
`default_nettype wire
